//--- rtl/far_pkg.sv
// Purpose: Shared constants for the fault auto-restart sequencer
// Assumes: 10 MHz controller clock, parameters held in 0.1 s units
// Notes: Register map sits on a classic Wishbone slave, 32-bit words
package far_pkg;
    // Clock and timebase
    localparam int CLK_HZ = 10000000;
    localparam int TENTH_S_MS = 100;
    localparam int TENTH_CYCLES = CLK_HZ / 1000 * TENTH_S_MS;
    localparam int CREDIT_TIME_S = 60;
    localparam logic [9:0] CREDIT_TENTHS = 10'h258;
    // Setting ranges
    localparam logic [3:0] RETRY_MAX = 4'hA;
    localparam logic [3:0] RETRY_DEF = 4'h6;
    localparam logic [9:0] WAIT_MIN = 10'h001;
    localparam logic [9:0] TIME_MAX = 10'h258;
    localparam logic [9:0] WAIT_DEF = 10'h00A;
    localparam logic [9:0] BLOCK_DEF = 10'h00A;
    localparam logic [13:0] GAIN_MAX = 14'h270F;
    localparam logic [13:0] PGAIN_DEF = 14'h0064;
    localparam logic [13:0] IGAIN_DEF = 14'h00C8;
    localparam logic [7:0] CUR_DEF = 8'h96;
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_TIME = 5'h04;
    localparam logic [4:0] OFS_GAIN = 5'h08;
    localparam logic [4:0] OFS_STAT = 5'h0C;
    localparam logic [4:0] OFS_IRQ = 5'h10;
    localparam logic [4:0] OFS_MASK = 5'h14;
    // Interrupt bit positions
    localparam int IRQ_TRIP = 0;
    localparam int IRQ_RESTART = 1;
    localparam int IRQ_EXHAUST = 2;
    localparam int IRQ_CREDIT = 3;
    localparam int IRQ_W = 4;
    // Sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_TRIPPED = 5'b00010,
        ST_WAIT = 5'b00100,
        ST_BLOCK = 5'b01000,
        ST_SEARCH = 5'b10000
    } far_state_e;
endpackage : far_pkg

//--- rtl/far_tick.sv
// Purpose: One-cycle enable every tenth of a second
// Assumes: Single clock domain
// Notes: Counts clk_i cycles
`timescale 1ns/1ps
`default_nettype none
module far_tick #(
    parameter int CYCLES = far_pkg::TENTH_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Enable pulse
    output logic tick_o
);
    import far_pkg::*;
    logic [23:0] cnt_reg;
    logic [23:0] cnt_next;
    logic tick_next;

    // Divider next state
    always_comb begin
        tick_next = 1'b0;
        cnt_next = cnt_reg + 24'h000001;
        if (cnt_reg == 24'(CYCLES - 1)) begin
            cnt_next = 24'h000000;
            tick_next = 1'b1;
        end
    end

    // Divider registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 24'h000000;
            tick_o <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_o <= tick_next;
        end
    end
endmodule : far_tick
`default_nettype wire

//--- rtl/far_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Asynchronous level inputs
// Notes: Output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module far_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    import far_pkg::*;
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // Per-bit stages and filter
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                s1_reg[i] <= 1'b0;
                s2_reg[i] <= 1'b0;
                s3_reg[i] <= 1'b0;
                q_o[i] <= 1'b0;
            end else begin
                s1_reg[i] <= d_i[i];
                s2_reg[i] <= s1_reg[i];
                s3_reg[i] <= s2_reg[i];
                if (s2_reg[i] == s3_reg[i]) begin
                    q_o[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule : far_sync
`default_nettype wire

//--- rtl/far_seq.sv
// Functional notes
// - Restart after a fault reset only when restart-on-reset is enabled.
// - Retry limit accepts 0 to 10 and resets to 6.
// - Wait the retry delay (0.1 to 60.0 s, default 1.0 s) before a restart.
// - Each restart takes one retry; none happen once the count is zero. The code's fault-reset restart takes no retry and runs even at zero.
// - Sixty seconds without a trip after a restart credits one retry.
// - The credited count never exceeds the retry limit.
// - Low voltage, emergency stop, overheat or hardware faults block restart.
// - Every auto restart goes through the speed-search procedure.
// - Output is blocked for 0.0 to 60.0 s before a speed search.
// - Search gains range 0 to 9999, integral 200, proportional 100.
// - A four-bit field selects speed search per start condition; the code only stores it in sel_reg and every restart searches.
// - Over the search current limit, hold voltage and lower frequency.
//
// Purpose: Fault auto-restart sequencer with speed-search start-up
// Assumes: Trip and cause pins are asynchronous; current flag likewise
// Notes: Times in 0.1 s units; Wishbone classic slave, one wait state
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module far_seq #(
    parameter int TICK_CYCLES = far_pkg::TENTH_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Drive status pins
    input wire logic trip_i,
    input wire logic fault_reset_i,
    input wire logic [3:0] cause_i,
    input wire logic over_limit_i,
    // Drive control
    output logic output_block_o,
    output logic search_active_o,
    output logic volt_hold_o,
    output logic freq_lower_o,
    output logic restart_o,
    output logic irq_o
);
    import far_pkg::*;

    // ----------------------------------------------------------------
    // Input conditioning
    // ----------------------------------------------------------------
    logic tick;
    logic [6:0] pins;
    logic trip_s, rst_s, over_s;
    logic [3:0] cause_s;
    logic trip_d_reg, rst_d_reg;

    far_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    far_sync #(.W(7)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({over_limit_i, cause_i, fault_reset_i, trip_i}),
        .q_o(pins)
    );
    assign trip_s = pins[0];
    assign rst_s = pins[1];
    assign cause_s = pins[5:2];
    assign over_s = pins[6];

    // Edge history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trip_d_reg <= 1'b0;
            rst_d_reg <= 1'b0;
        end else begin
            trip_d_reg <= trip_s;
            rst_d_reg <= rst_s;
        end
    end

    logic trip_rise, reset_rise;
    assign trip_rise = trip_s & ~trip_d_reg;
    assign reset_rise = rst_s & ~rst_d_reg;

    // ----------------------------------------------------------------
    // Settings registers
    // ----------------------------------------------------------------
    logic en_reg, en_next;
    logic [3:0] limit_reg, limit_next, sel_reg, sel_next;
    logic [7:0] cur_reg, cur_next;
    logic [9:0] wait_reg, wait_next, block_reg, block_next;
    logic [13:0] pgain_reg, pgain_next, igain_reg, igain_next;
    logic [IRQ_W-1:0] sts_reg, sts_next, mask_reg, mask_next;
    logic [31:0] dat_next;
    logic ack_next, wr;
    logic [IRQ_W-1:0] ev;

    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

    // Register writes, range clamps and status flags
    always_comb begin
        en_next = en_reg;
        limit_next = limit_reg;
        sel_next = sel_reg;
        cur_next = cur_reg;
        wait_next = wait_reg;
        block_next = block_reg;
        pgain_next = pgain_reg;
        igain_next = igain_reg;
        mask_next = mask_reg;
        sts_next = sts_reg;
        if (wr && wb_adr_i == OFS_CTRL) begin
            if (wb_sel_i[0]) begin
                en_next = wb_dat_i[0];
                limit_next = (wb_dat_i[7:4] > RETRY_MAX) ? RETRY_MAX
                                                         : wb_dat_i[7:4];
            end
            if (wb_sel_i[1]) begin
                sel_next = wb_dat_i[11:8];
            end
            if (wb_sel_i[2]) begin
                cur_next = wb_dat_i[23:16];
            end
        end
        if (wr && wb_adr_i == OFS_TIME) begin
            if (wb_sel_i[1:0] == 2'h3) begin
                wait_next = (wb_dat_i[9:0] < WAIT_MIN) ? WAIT_MIN :
                            (wb_dat_i[9:0] > TIME_MAX) ? TIME_MAX
                                                       : wb_dat_i[9:0];
            end
            if (wb_sel_i[3:2] == 2'h3) begin
                block_next = (wb_dat_i[25:16] > TIME_MAX) ? TIME_MAX
                                                          : wb_dat_i[25:16];
            end
        end
        if (wr && wb_adr_i == OFS_GAIN) begin
            if (wb_sel_i[1:0] == 2'h3) begin
                pgain_next = (wb_dat_i[13:0] > GAIN_MAX) ? GAIN_MAX
                                                         : wb_dat_i[13:0];
            end
            if (wb_sel_i[3:2] == 2'h3) begin
                igain_next = (wb_dat_i[29:16] > GAIN_MAX) ? GAIN_MAX
                                                          : wb_dat_i[29:16];
            end
        end
        if (wr && wb_adr_i == OFS_MASK && wb_sel_i[0]) begin
            mask_next = wb_dat_i[IRQ_W-1:0];
        end
        // Write one clears, a new event wins
        if (wr && wb_adr_i == OFS_IRQ && wb_sel_i[0]) begin
            sts_next = sts_reg & ~wb_dat_i[IRQ_W-1:0];
        end
        sts_next = sts_next | ev;
    end

    // ----------------------------------------------------------------
    // Restart sequencer
    // ----------------------------------------------------------------
    far_state_e state_reg, state_next;
    logic [3:0] left_reg, left_next;
    logic [9:0] tmr_reg, tmr_next, credit_reg, credit_next;
    logic credit_run_reg, credit_run_next;
    logic blocked_reg, blocked_next;
    logic restart_next, block_out_next, search_next, hold_next, lower_next;

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        left_next = left_reg;
        tmr_next = tmr_reg;
        credit_next = credit_reg;
        credit_run_next = credit_run_reg;
        blocked_next = blocked_reg;
        restart_next = 1'b0;
        ev = '0;
        if (left_reg > limit_reg) begin
            left_next = limit_reg;
        end
        if (credit_run_reg && tick) begin
            if (credit_reg == CREDIT_TENTHS - 10'h001) begin
                credit_run_next = 1'b0;
                credit_next = 10'h000;
                if (left_reg < limit_reg) begin
                    left_next = left_reg + 4'h1;
                    ev[IRQ_CREDIT] = 1'b1;
                end
            end else begin
                credit_next = credit_reg + 10'h001;
            end
        end
        unique case (state_reg)
            ST_IDLE: begin
                // Waits for a trip, taken below
            end
            ST_TRIPPED: begin
                if (blocked_reg || left_reg == 4'h0) begin
                    if (!blocked_reg) begin
                        ev[IRQ_EXHAUST] = 1'b1;
                    end
                    blocked_next = 1'b1;
                    if (reset_rise) begin
                        state_next = en_reg ? ST_BLOCK : ST_IDLE;
                        tmr_next = 10'h000;
                        blocked_next = 1'b0;
                    end
                end else begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // retry delay; a limit cut to zero ends the wait
                if (left_reg == 4'h0) begin
                    state_next = ST_TRIPPED;
                end else if (tick) begin
                    tmr_next = tmr_reg + 10'h001;
                    if (tmr_reg + 10'h001 >= wait_reg) begin
                        left_next = left_reg - 4'h1;
                        credit_run_next = 1'b1;
                        credit_next = 10'h000;
                        ev[IRQ_RESTART] = 1'b1;
                        state_next = ST_BLOCK;
                        tmr_next = 10'h000;
                    end
                end
            end
            ST_BLOCK: begin
                if (tmr_reg >= block_reg) begin
                    state_next = ST_SEARCH;
                    restart_next = 1'b1;
                end else if (tick) begin
                    tmr_next = tmr_reg + 10'h001;
                end
            end
            ST_SEARCH: begin
                // Drive returns to normal when trip clears and current ok
                if (!over_s && !trip_s) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // A trip in any state enters the trip path
        if (trip_rise) begin
            ev[IRQ_TRIP] = 1'b1;
            credit_run_next = 1'b0;
            credit_next = 10'h000;
            blocked_next = |cause_s;
            state_next = ST_TRIPPED;
            tmr_next = 10'h000;
        end
    end

    // Output steering
    always_comb begin
        block_out_next = state_next == ST_TRIPPED || state_next == ST_WAIT
                         || state_next == ST_BLOCK;
        search_next = state_next == ST_SEARCH;
        hold_next = search_next & over_s;
        lower_next = search_next & over_s;
    end

    // Sequencer and settings registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            left_reg <= RETRY_DEF;
            tmr_reg <= 10'h000;
            credit_reg <= 10'h000;
            credit_run_reg <= 1'b0;
            blocked_reg <= 1'b0;
            en_reg <= 1'b0;
            limit_reg <= RETRY_DEF;
            sel_reg <= 4'h0;
            cur_reg <= CUR_DEF;
            wait_reg <= WAIT_DEF;
            block_reg <= BLOCK_DEF;
            pgain_reg <= PGAIN_DEF;
            igain_reg <= IGAIN_DEF;
            sts_reg <= '0;
            mask_reg <= '0;
            output_block_o <= 1'b0;
            search_active_o <= 1'b0;
            volt_hold_o <= 1'b0;
            freq_lower_o <= 1'b0;
            restart_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            left_reg <= left_next;
            tmr_reg <= tmr_next;
            credit_reg <= credit_next;
            credit_run_reg <= credit_run_next;
            blocked_reg <= blocked_next;
            en_reg <= en_next;
            limit_reg <= limit_next;
            sel_reg <= sel_next;
            cur_reg <= cur_next;
            wait_reg <= wait_next;
            block_reg <= block_next;
            pgain_reg <= pgain_next;
            igain_reg <= igain_next;
            sts_reg <= sts_next;
            mask_reg <= mask_next;
            output_block_o <= block_out_next;
            search_active_o <= search_next;
            volt_hold_o <= hold_next;
            freq_lower_o <= lower_next;
            restart_o <= restart_next;
            irq_o <= |(sts_next & mask_next);
        end
    end

    // ----------------------------------------------------------------
    // Wishbone read path
    // ----------------------------------------------------------------
    always_comb begin
        ack_next = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        dat_next = 32'h00000000;
        unique case (wb_adr_i)
            OFS_CTRL: dat_next = {8'h00, cur_reg, 4'h0, sel_reg,
                                  limit_reg, 3'h0, en_reg};
            OFS_TIME: dat_next = {6'h00, block_reg, 6'h00, wait_reg};
            OFS_GAIN: dat_next = {2'h0, igain_reg, 2'h0, pgain_reg};
            OFS_STAT: dat_next = {19'h00000, state_reg, 4'h0, left_reg};
            OFS_IRQ: dat_next = {28'h0000000, sts_reg};
            OFS_MASK: dat_next = {28'h0000000, mask_reg};
            default: dat_next = 32'h00000000;
        endcase
    end

    // Bus answer registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= ack_next;
            wb_dat_o <= dat_next;
        end
    end
endmodule : far_seq
`default_nettype wire

//--- bench/far_motor_model.sv
// Purpose: Motor seen from the sequencer during a restart search
// Assumes: Current rises at search start, falls while frequency drops
// Notes: surge_i sets how long the inrush outlasts the limit
`timescale 1ns/1ps
`default_nettype none
module far_motor_model (
    // Clock
    input wire logic clk_i,
    // Drive state
    input wire logic search_active_i,
    input wire logic freq_lower_i,
    input wire logic [3:0] surge_i,
    // Current flag
    output logic over_limit_o
);
    logic [3:0] left_cnt;

    // Inrush stays high until the drive has lowered frequency long enough
    always @(posedge clk_i) begin
        if (!search_active_i) begin
            left_cnt <= surge_i;
            over_limit_o <= 1'b0;
        end else if (left_cnt != 4'h0) begin
            over_limit_o <= 1'b1;
            if (freq_lower_i) begin
                left_cnt <= left_cnt - 4'h1;
            end
        end else begin
            over_limit_o <= 1'b0;
        end
    end
endmodule : far_motor_model
`default_nettype wire

//--- bench/far_seq_props.sv
// Purpose: Port checks for the auto-restart sequencer
// Assumes: One clock, synchronous active-high reset
// Notes: Bound into every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module far_seq_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic trip_i,
    input wire logic output_block_o,
    input wire logic search_active_o,
    input wire logic volt_hold_o,
    input wire logic freq_lower_o,
    input wire logic restart_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus answer timing
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack missing after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    // Current limit response
    AST_HOLD_PAIR: assert property (volt_hold_o == freq_lower_o)
        else $error("hold and lower disagree");
    AST_HOLD_SEARCH: assert property ((volt_hold_o || freq_lower_o)
        |-> search_active_o) else $error("hold outside search");
    // Block before search
    AST_BLOCK_EXCL: assert property (
        !(output_block_o && search_active_o))
        else $error("block and search together");
    AST_SEARCH_AFTER_BLOCK: assert property ($rose(search_active_o)
        |-> $past(output_block_o)) else $error("search without block");
    // Restart pulse and trip blocking
    AST_RESTART_SEARCH: assert property ($rose(search_active_o)
        |-> restart_o || $past(restart_o)) else $error("search no pulse");
    AST_RESTART_PULSE: assert property (restart_o |=> !restart_o)
        else $error("restart pulse too long");
    AST_TRIP_BLOCK: assert property ($rose(trip_i)
        |-> ##[1:8] output_block_o) else $error("trip not blocking");

    // Main scenarios
    COV_RESTART: cover property (restart_o);
    COV_HOLD: cover property (volt_hold_o);
    COV_ACK: cover property (wb_ack_o);
endmodule : far_seq_props

bind far_seq far_seq_props far_seq_props_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .trip_i(trip_i),
    .output_block_o(output_block_o),
    .search_active_o(search_active_o),
    .volt_hold_o(volt_hold_o),
    .freq_lower_o(freq_lower_o),
    .restart_o(restart_o)
);
`default_nettype wire

//--- bench/tb_top.sv
// Purpose: Self-checking bench for the auto-restart sequencer
// Assumes: Tick shortened to 10 cycles; one wait-state bus slave
// Notes: Random delays and surges from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import far_pkg::*;
    localparam int TK = 10;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic trip_i, fault_reset_i, over_limit_i, output_block_o, irq_o;
    logic search_active_o, volt_hold_o, freq_lower_o, restart_o;
    logic [4:0] wb_adr_i;
    logic [3:0] wb_sel_i, cause_i, surge;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    int error_cnt, comparisons, w, b;

    far_seq #(.TICK_CYCLES(TK)) far_seq_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trip_i(trip_i),
        .fault_reset_i(fault_reset_i), .cause_i(cause_i),
        .over_limit_i(over_limit_i), .output_block_o(output_block_o),
        .search_active_o(search_active_o), .volt_hold_o(volt_hold_o),
        .freq_lower_o(freq_lower_o), .restart_o(restart_o), .irq_o(irq_o));
    far_motor_model far_motor_model_i (.clk_i(clk_i),
        .search_active_i(search_active_o), .freq_lower_i(freq_lower_o),
        .surge_i(surge), .over_limit_o(over_limit_i));

    // Clock
    always #50 clk_i = ~clk_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Classic bus cycle, held until ack is sampled
    task automatic wb(input logic [4:0] a, input logic we,
                      input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb

    function automatic logic [31:0] ctrl_w(logic en, logic [3:0] lim);
        return {8'h00, 8'h96, 4'h0, 4'hF, lim, 3'h0, en};
    endfunction : ctrl_w

    // Earliest and latest restart after a trip, in cycles
    function automatic int lo_t(int wt, int bt);
        return (wt - 1) * TK + ((bt > 0) ? (bt - 1) * TK : 0);
    endfunction : lo_t
    function automatic int hi_t(int wt, int bt);
        return (wt + bt) * TK + 16;
    endfunction : hi_t

    task automatic stat(input logic [3:0] left);
        wb(OFS_STAT, 1'b0, 32'h0);
        chk({28'h0, rd[3:0]}, {28'h0, left});
    endtask : stat

    task automatic set_time;
        w = 1 + $urandom % 3;
        b = $urandom % 3;
        wb(OFS_TIME, 1'b1, {6'h0, 10'(b), 6'h0, 10'(w)});
    endtask : set_time

    // Trip, time the restart, then let the search settle
    task automatic do_trip(input logic [3:0] c, input logic exp_rs);
        int n;
        int h;
        n = 0;
        h = 0;
        @(posedge clk_i);
        cause_i <= c;
        surge <= 4'($urandom % 6);
        @(posedge clk_i);
        trip_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (restart_o !== 1'b1 && n < 400);
        trip_i <= 1'b0;
        cause_i <= 4'h0;
        if (exp_rs) begin
            chk(32'(n >= lo_t(w, b) && n <= hi_t(w, b)), 32'h1);
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
                h += int'(volt_hold_o === 1'b1);
            end while (search_active_o !== 1'b0 && n < 200);
            chk({31'h0, search_active_o}, 32'h0);
            chk(32'(h > 0), 32'(surge != 4'h0));
        end else begin
            chk(32'(n), 32'h190);
        end
    endtask : do_trip

    task automatic do_reset(input logic exp_rs);
        int n;
        n = 0;
        @(posedge clk_i);
        fault_reset_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (restart_o !== 1'b1 && n < 150);
        fault_reset_i <= 1'b0;
        chk(32'(n < 150), 32'(exp_rs));
        repeat (80) @(posedge clk_i);
    endtask : do_reset

    task automatic final_report;
        $display("Comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // Watchdog
    initial begin
        repeat (40000) @(posedge clk_i);
        error_cnt++;
        final_report();
    end

    // Main sequence
    initial begin
        {clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h08;
        {trip_i, fault_reset_i, cause_i, surge} = 10'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i} = {9'h00F, 32'h0};
        w = $urandom(32'hF20F23CB);
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(OFS_STAT, 1'b0, 32'h0);
        chk(rd, 32'h00000106);
        wb(OFS_TIME, 1'b0, 32'h0);
        chk(rd, {6'h0, BLOCK_DEF, 6'h0, WAIT_DEF});
        wb(OFS_GAIN, 1'b0, 32'h0);
        chk(rd, {2'h0, IGAIN_DEF, 2'h0, PGAIN_DEF});
        wb(OFS_CTRL, 1'b0, 32'h0);
        chk(rd & 32'h00FF00F1, 32'h00960060);
        wb(5'h18, 1'b0, 32'h0);
        chk(rd, 32'h0);
        // Out-of-range settings clamp
        wb(OFS_CTRL, 1'b1, ctrl_w(1'b0, 4'hF));
        wb(OFS_CTRL, 1'b0, 32'h0);
        chk({28'h0, rd[7:4]}, {28'h0, RETRY_MAX});
        wb(OFS_TIME, 1'b1, 32'h03FF0000);
        wb(OFS_TIME, 1'b0, 32'h0);
        chk(rd, {6'h0, TIME_MAX, 6'h0, WAIT_MIN});
        wb(OFS_GAIN, 1'b1, 32'hFFFFFFFF);
        wb(OFS_GAIN, 1'b0, 32'h0);
        chk(rd, {2'h0, GAIN_MAX, 2'h0, GAIN_MAX});
        wb(OFS_CTRL, 1'b1, ctrl_w(1'b0, 4'h6));
        wb(OFS_CTRL, 1'b0, 32'h0);
        chk({28'h0, rd[11:8]}, 32'hF);
        wb(OFS_MASK, 1'b1, 32'(1 << IRQ_EXHAUST));
        // One restart, then credit after a quiet minute, capped
        set_time();
        do_trip(4'h0, 1'b1);
        stat(4'h5);
        repeat (5900) @(posedge clk_i);
        stat(4'h5);
        repeat (200) @(posedge clk_i);
        stat(4'h6);
        repeat (6100) @(posedge clk_i);
        stat(4'h6);
        // Blocking causes need a fault reset; restart stays off
        for (int i = 0; i < 4; i++) begin
            set_time();
            do_trip(4'h1 << i, 1'b0);
            stat(4'h6);
            do_reset(1'b0);
        end
        // Lowering the limit pulls the count down
        wb(OFS_CTRL, 1'b1, ctrl_w(1'b0, 4'h4));
        stat(4'h4);
        wb(OFS_CTRL, 1'b1, ctrl_w(1'b0, 4'h6));
        // Use up every retry
        for (int i = 3; i >= 0; i--) begin
            set_time();
            do_trip(4'h0, 1'b1);
            stat(4'(i));
        end
        chk({31'h0, irq_o}, 32'h0);
        do_trip(4'h0, 1'b0);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h1);
        wb(OFS_IRQ, 1'b1, 32'hF);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        // Restart on fault reset only when enabled
        wb(OFS_CTRL, 1'b1, ctrl_w(1'b1, 4'h6));
        do_reset(1'b1);
        stat(4'h0);
        wb(OFS_CTRL, 1'b1, ctrl_w(1'b0, 4'h0));
        set_time();
        do_trip(4'h0, 1'b0);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
